// ### hdl/hbd_lock_order.sv
// bridge lock detection, resolution, speculative request and ordering control
//
// How it works
// RULE1: each slave side raises stall while its transaction needs the opposite bus
// RULE2: both stalls together is bridge lock; processor-side slave backs out unless its cycle is a posted write
// RULE3: a processor read hit by resolution ends in retry and drops partial data
// RULE4: posted processor writes finish under resolution; non-posted writes are retried
// RULE5: masters should place non-posted sensitive writes on mod-4 boundaries
// RULE6: the pci master logic decides resolution and removes the queued command
// RULE7: resolution also fires on programmable write or read fifo thresholds
// RULE8: optional early back-out of a stalled cycle on any pci slave activity
// RULE9: resolution on a compelled cycle raises a speculative pci request if enabled
// RULE10: an unused speculative request drops after 16 clocks
// RULE11: speculative requesting is on after reset and software can turn it off
// RULE12: commands leave toward pci in the order they arrived
// RULE13: reads and compelled writes wait until earlier posted writes are drained
// RULE14: pci config to own registers waits while posted writes are outstanding
// RULE15: processor access to own registers waits for all its posted writes
// RULE16: with cpu flush-before-read a processor read waits for an empty pci fifo
// RULE17: with cpu flush-before-read a read retries while pci posted write is pending
// RULE18: with pci flush-before-read a pci read waits for an empty cpu-bound fifo
// RULE19: cpu posted-pending sets on posted commit, holds until pci fifo empties
// RULE20: with pci flush-before-read a pci read retries while cpu posted is pending
// RULE21: the two flush-before-read controls act independently
// RULE22: pci-side indications pass a two-flop synchroniser before use
`timescale 1ns/1ps
module hbd_lock_order
  import hbd_pkg::*;
#(
  parameter int CMD_W = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ctl_write,
  input wire logic ctl_spec_enable,
  input wire logic [THR_W-1:0] write_lock_threshold,
  input wire logic [THR_W-1:0] read_lock_threshold,
  input wire logic cpu_flush_before_read,
  input wire logic pci_flush_before_read,
  input wire logic release_on_pci_activity,
  input wire logic cpu_req,
  input wire logic [1:0] cpu_kind,
  input wire logic [CMD_W-1:0] cpu_cmd,
  input wire logic cpu_rd_avail,
  input wire logic cpu_cpl,
  input wire logic [THR_W-1:0] pci_fifo_level,
  input wire logic pci_fifo_full,
  input wire logic pci_bound_empty,
  input wire logic cpu_bound_empty,
  input wire logic pci_active,
  input wire logic pci_rd_nodata,
  input wire logic pci_nonposted,
  input wire logic pci_posted,
  input wire logic pci_read_decoded,
  input wire logic pci_cfg_own,
  input wire logic pci_posted_pending,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [1:0] cmd_kind,
  output logic [CMD_W-1:0] cmd_data,
  output logic cpu_ack,
  output logic cpu_retry,
  output logic cpu_wait,
  output logic cpu_stall,
  output logic cpu_posted_pending,
  output logic pci_stall,
  output logic bridge_lock,
  output logic pci_req,
  output logic pci_read_wait,
  output logic pci_read_retry,
  output logic pci_cfg_hold,
  output logic speculative_request_enable
);
  hbd_cpu_state_type state;
  hbd_cpu_state_type next_state;
  logic [1:0] kind_q;
  logic [CMD_W-1:0] cmd_q;
  logic [6:0] pci_raw;
  logic [6:0] pci_s;
  logic act_s, nodata_s, nonpost_s, post_s, rdec_s, cfg_s, ppend_s;
  logic skid_in_ready;
  logic [CMD_W+1:0] skid_out;
  logic drained, compelled, cpu_stall_now, pci_stall_now;
  logic both_stalled, wthr_hit, rthr_hit, lock_go;
  logic push, ack_now, retry_now, wait_now, flush;
  logic spec_act;
  logic [4:0] spec_cnt;

  if (CMD_W < 8) begin : g_bad_cmd_w
    $error("hbd_lock_order: CMD_W must be at least 8");
  end

  // threshold compare shared by the write and read triggers
  function automatic logic thr_hit(input logic [THR_W-1:0] thr,
                                   input logic [THR_W-1:0] level,
                                   input logic edge_flag,
                                   input logic is_read);
    if (thr == THR_FIFO_FULL) begin
      thr_hit = edge_flag;
    end else if (is_read) begin
      thr_hit = (level <= thr);
    end else begin
      thr_hit = (level >= thr);
    end
  endfunction : thr_hit

  // pci slave levels come from the other clock domain
  assign pci_raw = {pci_posted_pending, pci_cfg_own, pci_read_decoded, pci_posted,
                    pci_nonposted, pci_rd_nodata, pci_active};
  hbd_sync #(.WIDTH(7)) u_sync (  // RULE22
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(pci_raw),
    .sync_out(pci_s)
  );
  assign {ppend_s, cfg_s, rdec_s, post_s, nonpost_s, nodata_s, act_s} = pci_s;

  // pci-bound command queue; a stalled pci master side back-pressures the fsm
  hbd_skid #(.WIDTH(CMD_W + 2)) u_skid (  // RULE12
    .sys_clk(sys_clk),
    .srst(srst),
    .flush(flush),
    .in_valid(push),
    .in_data({kind_q, cmd_q}),
    .in_ready(skid_in_ready),
    .out_valid(cmd_valid),
    .out_data(skid_out),
    .out_ready(cmd_ready)
  );
  assign cmd_kind = skid_out[CMD_W+1:CMD_W];
  assign cmd_data = skid_out[CMD_W-1:0];

  // drained: nothing processor-originated is left on its way to pci
  assign drained = pci_bound_empty && !cmd_valid;
  assign compelled = (kind_q == KIND_READ) || (kind_q == KIND_NONPOSTED);

  // stall terms of both slaves toward the pci master logic
  assign cpu_stall_now = (state != CS_IDLE) &&
                         (((kind_q == KIND_READ) && !cpu_rd_avail) ||
                          (kind_q == KIND_NONPOSTED) ||
                          ((kind_q == KIND_POSTED) && !skid_in_ready));  // RULE1
  assign pci_stall_now = act_s && (nodata_s || nonpost_s ||
                                   (post_s && pci_fifo_full));  // RULE1

  // lock decision lives here, next to the queue it may have to empty
  assign both_stalled = cpu_stall_now && pci_stall_now;  // RULE2
  assign wthr_hit = act_s && post_s &&
                    thr_hit(write_lock_threshold, pci_fifo_level, pci_fifo_full, 1'b0);  // RULE7
  assign rthr_hit = act_s && rdec_s &&
                    thr_hit(read_lock_threshold, pci_fifo_level, nodata_s, 1'b1);  // RULE7
  // posted writes are never backed out since they are guaranteed to finish
  assign lock_go = cpu_stall_now && compelled &&
                   (both_stalled || wthr_hit || rthr_hit ||
                    (release_on_pci_activity && act_s));  // RULE6 RULE8 RULE4

  // processor-side slave sequencing
  always_comb begin
    next_state = state;
    push = 1'b0;
    ack_now = 1'b0;
    retry_now = 1'b0;
    wait_now = 1'b0;
    flush = 1'b0;
    case (state)
      CS_IDLE: begin
        if (cpu_req) begin
          next_state = CS_DRAIN;
        end
      end
      CS_DRAIN: begin
        case (kind_q)
          KIND_POSTED: begin
            push = 1'b1;  // RULE4
            if (skid_in_ready) begin
              ack_now = 1'b1;
              next_state = CS_IDLE;
            end else begin
              wait_now = 1'b1;
            end
          end
          KIND_OWN_REG: begin
            if (drained && !cpu_posted_pending) begin  // RULE15
              ack_now = 1'b1;
              next_state = CS_IDLE;
            end else begin
              wait_now = 1'b1;
            end
          end
          default: begin
            if (kind_q == KIND_READ && cpu_flush_before_read && ppend_s) begin
              retry_now = 1'b1;  // RULE17
              next_state = CS_IDLE;
            end else if (lock_go) begin
              retry_now = 1'b1;  // RULE3 RULE4
              next_state = CS_IDLE;
            end else if (drained) begin  // RULE13 RULE16
              push = 1'b1;
              next_state = CS_ISSUED;
            end else begin
              wait_now = 1'b1;
            end
          end
        endcase
      end
      CS_ISSUED: begin
        if (lock_go) begin
          retry_now = 1'b1;  // RULE3
          flush = 1'b1;  // RULE6
          next_state = CS_IDLE;
        end else if ((kind_q == KIND_READ) ? cpu_rd_avail : cpu_cpl) begin
          ack_now = 1'b1;
          next_state = CS_IDLE;
        end else begin
          wait_now = 1'b1;
        end
      end
      default: begin
        next_state = CS_IDLE;
      end
    endcase
  end

  // state and captured request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= CS_IDLE;
      kind_q <= KIND_READ;
      cmd_q <= '0;
    end else begin
      state <= next_state;
      if (state == CS_IDLE && cpu_req) begin
        kind_q <= cpu_kind;
        cmd_q <= cpu_cmd;
      end
    end
  end

  // processor-side answers; a retry drops whatever read data arrived so far
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_ack <= 1'b0;
      cpu_retry <= 1'b0;
      cpu_wait <= 1'b0;
      cpu_stall <= 1'b0;
      pci_stall <= 1'b0;
      bridge_lock <= 1'b0;
    end else begin
      cpu_ack <= ack_now;
      cpu_retry <= retry_now;  // RULE3
      cpu_wait <= wait_now;
      cpu_stall <= cpu_stall_now;
      pci_stall <= pci_stall_now;
      bridge_lock <= both_stalled;
    end
  end

  // posted-pending: a commit in the same cycle as the drain wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_posted_pending <= 1'b0;
    end else if (push && kind_q == KIND_POSTED && skid_in_ready) begin
      cpu_posted_pending <= 1'b1;  // RULE19
    end else if (drained) begin
      cpu_posted_pending <= 1'b0;  // RULE19
    end
  end

  // software control of speculative requesting
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speculative_request_enable <= SPEC_EN_RESET;  // RULE11
    end else if (ctl_write) begin
      speculative_request_enable <= ctl_spec_enable;  // RULE11
    end
  end

  // speculative request: benign, so it is withdrawn on its own after a fixed time
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spec_act <= 1'b0;
      spec_cnt <= '0;
    end else if (lock_go && speculative_request_enable) begin
      spec_act <= 1'b1;  // RULE9
      spec_cnt <= SPEC_CLOCKS;
    end else if (cmd_valid || spec_cnt == 5'h01) begin
      spec_act <= 1'b0;  // RULE10
      spec_cnt <= '0;
    end else if (spec_act) begin
      spec_cnt <= spec_cnt - 5'h01;
    end
  end

  // a queued command turns the speculative request into a real one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pci_req <= 1'b0;
    end else begin
      pci_req <= spec_act || cmd_valid;
    end
  end

  // pci-side holds; each flush control looks only at its own direction
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pci_read_wait <= 1'b0;
      pci_read_retry <= 1'b0;
      pci_cfg_hold <= 1'b0;
    end else begin
      pci_read_wait <= pci_flush_before_read && rdec_s && !cpu_bound_empty;  // RULE18 RULE21
      pci_read_retry <= pci_flush_before_read && rdec_s && cpu_posted_pending;  // RULE20 RULE21
      pci_cfg_hold <= cfg_s && (cpu_posted_pending || !cpu_bound_empty || ppend_s);  // RULE14
    end
  end

  // helper: length of an unused speculative request
  logic [5:0] spec_run;
  always_ff @(posedge sys_clk) begin
    if (srst || !spec_act) begin
      spec_run <= '0;
    end else begin
      spec_run <= spec_run + 6'h01;
    end
  end

  a_spec_limit: assert property (@(posedge sys_clk) disable iff (srst)  // RULE10
    spec_run <= 6'h10) else $error("speculative request held over 16 clocks");
  a_spec_start: assert property (@(posedge sys_clk) disable iff (srst)  // RULE9
    (lock_go && speculative_request_enable) |=> ##1 pci_req)
    else $error("no speculative request after lock resolution");
  a_spec_default: assert property (@(posedge sys_clk)  // RULE11
    srst |=> speculative_request_enable) else $error("speculative mode not on after reset");
  a_lock_retry: assert property (@(posedge sys_clk) disable iff (srst)  // RULE2
    (both_stalled && compelled && state != CS_IDLE) |=> cpu_retry && state == CS_IDLE)
    else $error("bridge lock did not retry the processor cycle");
  a_posted_finish: assert property (@(posedge sys_clk) disable iff (srst)  // RULE4
    (state == CS_DRAIN && kind_q == KIND_POSTED) |=> !cpu_retry)
    else $error("posted write was retried");
  a_stall_nonposted: assert property (@(posedge sys_clk) disable iff (srst)  // RULE1
    (state != CS_IDLE && kind_q == KIND_NONPOSTED) |=> cpu_stall)
    else $error("non-posted write without stall");
  a_fbr_retry: assert property (@(posedge sys_clk) disable iff (srst)  // RULE17
    (state == CS_DRAIN && kind_q == KIND_READ && cpu_flush_before_read && ppend_s)
    |=> cpu_retry) else $error("read not retried with pci posted write pending");
  a_issue_drained: assert property (@(posedge sys_clk) disable iff (srst)  // RULE13
    $rose(state == CS_ISSUED) |-> $past(drained))
    else $error("compelled cycle issued before posted writes drained");
  a_own_reg_order: assert property (@(posedge sys_clk) disable iff (srst)  // RULE15
    (cpu_ack && kind_q == KIND_OWN_REG) |-> $past(!cpu_posted_pending))
    else $error("own register access while posted writes pending");
  a_pending_hold: assert property (@(posedge sys_clk) disable iff (srst)  // RULE19
    (cpu_posted_pending && !drained) |=> cpu_posted_pending)
    else $error("posted-pending dropped before fifo empty");
  a_pci_retry: assert property (@(posedge sys_clk) disable iff (srst)  // RULE20
    pci_read_retry |-> $past(pci_flush_before_read && cpu_posted_pending))
    else $error("pci read retry without cause");
  a_cfg_hold: assert property (@(posedge sys_clk) disable iff (srst)  // RULE14
    (cfg_s && cpu_posted_pending) |=> pci_cfg_hold)
    else $error("config access not held with posted writes outstanding");
endmodule : hbd_lock_order

// ### hdl/hbd_pkg.sv
// shared constants and types for the bridge lock and ordering block
package hbd_pkg;
  // width of the lock threshold fields and of the pci fifo fill level
  localparam int THR_W = 4;
  // threshold code that keeps the old behaviour: resolve only on fifo full or empty
  localparam logic [THR_W-1:0] THR_FIFO_FULL = 4'h0;
  // processor-side transaction kinds
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_POSTED = 2'h1;
  localparam logic [1:0] KIND_NONPOSTED = 2'h2;
  localparam logic [1:0] KIND_OWN_REG = 2'h3;
  // speculative request lifetime in clocks
  localparam logic [4:0] SPEC_CLOCKS = 5'h10;
  // speculative requesting is on after reset
  localparam logic SPEC_EN_RESET = 1'b1;
  // processor-side slave states
  typedef enum logic [1:0] {CS_IDLE, CS_DRAIN, CS_ISSUED} hbd_cpu_state_type;
endpackage : hbd_pkg

// ### hdl/hbd_skid.sv
// two-entry command buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
module hbd_skid #(
  parameter int WIDTH = 34
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] tail;
  logic tail_vld;
  logic push;
  logic pop;

  if (WIDTH < 1) begin : g_bad_width
    $error("hbd_skid: WIDTH must be at least 1");
  end

  // head sits in out_data so the output comes straight from flops
  assign in_ready = !tail_vld;
  assign push = in_valid && !tail_vld;
  assign pop = out_valid && out_ready;

  // shift-style storage keeps entries strictly in arrival order
  always_ff @(posedge sys_clk) begin
    if (srst || flush) begin
      out_valid <= 1'b0;
      tail_vld <= 1'b0;
    end else begin
      if (pop) begin
        out_valid <= tail_vld || push;
        out_data <= tail_vld ? tail : in_data;
        tail_vld <= tail_vld && push;
        if (tail_vld && push) begin
          tail <= in_data;
        end
      end else if (push) begin
        if (!out_valid) begin
          out_valid <= 1'b1;
          out_data <= in_data;
        end else begin
          tail_vld <= 1'b1;
          tail <= in_data;
        end
      end
    end
  end
endmodule : hbd_skid

// ### hdl/hbd_sync.sv
// two-flop level synchroniser for signals from the pci slave domain
`timescale 1ns/1ps
module hbd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("hbd_sync: WIDTH must be at least 1");
  end

  // each bit is an independent level; meta feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : hbd_sync

// ### sim/hbd_far_model.sv
// far-side model: pci master end that takes queued commands and answers them
`timescale 1ns/1ps
module hbd_far_model
  import hbd_pkg::*;
#(
  parameter int CMD_W = 32,
  parameter int LAT = 3
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hold,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [CMD_W-1:0] cmd_data,
  input wire logic cpu_ack,
  input wire logic cpu_retry,
  output logic cmd_ready,
  output logic cpu_rd_avail,
  output logic cpu_cpl
);
  logic [CMD_W-1:0] log_q[$];
  logic busy;
  logic is_rd;
  int cnt;

  // one compelled command at a time; hold models a far side that stalls
  always @(posedge sys_clk) begin
    cpu_cpl <= 1'b0;
    if (srst) begin
      cmd_ready <= 1'b0;
      cpu_rd_avail <= 1'b0;
      busy <= 1'b0;
      is_rd <= 1'b0;
      cnt <= 0;
    end else begin
      cmd_ready <= ~hold & ~busy;
      if (cmd_valid && cmd_ready) begin
        log_q.push_back(cmd_data);
        if (cmd_kind != KIND_POSTED) begin
          busy <= 1'b1;
          is_rd <= (cmd_kind == KIND_READ);
          cnt <= LAT;
          cmd_ready <= 1'b0;
        end
      end
      if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end
      // read data stays offered until the processor side ends the cycle
      if (busy && cnt == 1) begin
        cpu_rd_avail <= is_rd;
        cpu_cpl <= ~is_rd;
        busy <= is_rd;
      end
      if (cpu_rd_avail && (cpu_ack || cpu_retry)) begin
        cpu_rd_avail <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : hbd_far_model

// ### sim/testbench.sv
// self-checking bench for the bridge lock and ordering block
`timescale 1ns/1ps
module testbench;
  import hbd_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic ctl_write = 1'b0, ctl_spec_enable = 1'b1, cpu_flush_before_read = 1'b0;
  logic pci_flush_before_read = 1'b0, release_on_pci_activity = 1'b0, cpu_req = 1'b0;
  logic [1:0] cpu_kind = 2'h0;
  logic [31:0] cpu_cmd = 32'h0;
  logic [THR_W-1:0] write_lock_threshold = 4'h0, read_lock_threshold = 4'h0;
  logic [THR_W-1:0] pci_fifo_level = 4'h0;
  logic pci_fifo_full = 1'b0, pci_bound_empty = 1'b1, cpu_bound_empty = 1'b1, hold = 1'b0;
  logic pci_active = 1'b0, pci_rd_nodata = 1'b0, pci_nonposted = 1'b0, pci_posted = 1'b0;
  logic pci_read_decoded = 1'b0, pci_cfg_own = 1'b0, pci_posted_pending = 1'b0;
  logic cmd_ready, cpu_rd_avail, cpu_cpl, cmd_valid, cpu_ack, cpu_retry, cpu_wait;
  logic cpu_stall, cpu_posted_pending, pci_stall, bridge_lock, pci_req, pci_read_wait;
  logic pci_read_retry, pci_cfg_hold, speculative_request_enable;
  logic [1:0] cmd_kind;
  logic [31:0] cmd_data;
  int error_cnt = 0, n_tests = 0;

  always #5 sys_clk = ~sys_clk;

  hbd_lock_order #(.CMD_W(32)) DUT (.sys_clk, .srst, .ctl_write, .ctl_spec_enable,
    .write_lock_threshold, .read_lock_threshold, .cpu_flush_before_read,
    .pci_flush_before_read, .release_on_pci_activity, .cpu_req, .cpu_kind, .cpu_cmd,
    .cpu_rd_avail, .cpu_cpl, .pci_fifo_level, .pci_fifo_full, .pci_bound_empty,
    .cpu_bound_empty, .pci_active, .pci_rd_nodata, .pci_nonposted, .pci_posted,
    .pci_read_decoded, .pci_cfg_own, .pci_posted_pending, .cmd_ready, .cmd_valid, .cmd_kind,
    .cmd_data, .cpu_ack, .cpu_retry, .cpu_wait, .cpu_stall, .cpu_posted_pending, .pci_stall,
    .bridge_lock, .pci_req, .pci_read_wait, .pci_read_retry, .pci_cfg_hold,
    .speculative_request_enable);

  hbd_far_model #(.CMD_W(32), .LAT(3)) far (.sys_clk, .srst, .hold, .cmd_valid, .cmd_kind,
    .cmd_data, .cpu_ack, .cpu_retry, .cmd_ready, .cpu_rd_avail, .cpu_cpl);

  task automatic conclude();
    $display("comparisons %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step

  // watched outputs by index, so one bounded wait serves them all
  function automatic logic mon(input int i);
    case (i)
      0: return cpu_ack;
      1: return cpu_retry;
      2: return cpu_posted_pending;
      3: return pci_read_retry;
      4: return pci_read_wait;
      5: return pci_cfg_hold;
      6: return bridge_lock;
      7: return cpu_wait;
      default: return far.log_q.size() == 3;
    endcase
  endfunction : mon

  task automatic wait_on(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (mon(i) !== v) begin
      step(1);
      n++;
      if (n > lim) begin
        check(mon(i), v);
        conclude();
      end
    end
  endtask : wait_on

  // inputs move on the falling edge; request stays up across one rising edge
  task automatic cpu_issue(input logic [1:0] kind, input logic [31:0] word);
    cpu_kind = kind;
    cpu_cmd = word;
    cpu_req = 1'b1;
    step(1);
    cpu_req = 1'b0;
  endtask : cpu_issue

  task automatic s_posted_pending();
    pci_bound_empty = 1'b0;
    cpu_issue(KIND_POSTED, 32'hA5A50001);
    wait_on(0, 1'b1, 4);
    wait_on(2, 1'b1, 2);
    pci_flush_before_read = 1'b1;
    pci_read_decoded = 1'b1;
    pci_cfg_own = 1'b1;
    wait_on(3, 1'b1, 6);
    wait_on(5, 1'b1, 6);
    check(cpu_posted_pending, 1'b1);
    pci_bound_empty = 1'b1;
    wait_on(2, 1'b0, 4);
    wait_on(3, 1'b0, 6);
    check(far.log_q.pop_front(), 32'hA5A50001);
    pci_flush_before_read = 1'b0;
    pci_read_decoded = 1'b0;
    pci_cfg_own = 1'b0;
    step(4);
  endtask : s_posted_pending

  // fill the two-entry queue while the far side stalls, then drain it
  task automatic s_order_buffer();
    logic seen_ack;
    seen_ack = 1'b0;
    far.log_q.delete();
    hold = 1'b1;
    step(1);
    cpu_issue(KIND_POSTED, 32'h00000011);
    wait_on(0, 1'b1, 4);
    cpu_issue(KIND_POSTED, 32'h00000022);
    wait_on(0, 1'b1, 4);
    cpu_issue(KIND_POSTED, 32'h00000033);
    repeat (6) begin
      step(1);
      seen_ack |= cpu_ack;
    end
    check(seen_ack, 1'b0);
    check(cpu_stall, 1'b1);
    hold = 1'b0;
    wait_on(0, 1'b1, 10);
    wait_on(8, 1'b1, 10);
    check(far.log_q.pop_front(), 32'h00000011);
    check(far.log_q.pop_front(), 32'h00000022);
    check(far.log_q.pop_front(), 32'h00000033);
    step(4);
  endtask : s_order_buffer

  // queued read meets pci slave activity: mode 0 non-posted, 1 write thr, 2 read thr
  task automatic s_lock_read(input logic [1:0] mode);
    logic lk;
    lk = (mode == 2'h0);
    hold = 1'b1;
    pci_nonposted = lk;
    pci_posted = (mode == 2'h1);
    pci_read_decoded = (mode == 2'h2);
    write_lock_threshold = (mode == 2'h1) ? 4'h4 : 4'h0;
    read_lock_threshold = (mode == 2'h2) ? 4'h6 : 4'h0;
    pci_fifo_level = 4'h5;
    cpu_issue(KIND_READ, 32'h00000100);
    step(1);
    check({cmd_valid, cmd_kind, cmd_data}, {1'b1, KIND_READ, 32'h00000100});
    pci_active = 1'b1;
    wait_on(6, lk, 12);
    wait_on(1, 1'b1, 4);
    check({cpu_ack, pci_stall}, {1'b0, lk});
    check(cmd_valid, 1'b0);
    step(15);
    check(pci_req, 1'b1);
    step(2);
    check(pci_req, 1'b0);
    pci_nonposted = 1'b0;
    pci_posted = 1'b0;
    pci_read_decoded = 1'b0;
    pci_active = 1'b0;
    pci_fifo_level = 4'h0;
    hold = 1'b0;
    step(5);
    check(64'(far.log_q.size()), 64'h0);
  endtask : s_lock_read

  task automatic s_spec_off();
    ctl_spec_enable = 1'b0;
    ctl_write = 1'b1;
    step(1);
    ctl_write = 1'b0;
    step(1);
    check(speculative_request_enable, 1'b0);
    hold = 1'b1;
    pci_nonposted = 1'b1;
    pci_active = 1'b1;
    step(4);
    cpu_issue(KIND_NONPOSTED, 32'h00001000);
    wait_on(1, 1'b1, 15);
    step(14);
    check(pci_req, 1'b0);
    pci_nonposted = 1'b0;
    pci_active = 1'b0;
    hold = 1'b0;
    ctl_spec_enable = 1'b1;
    ctl_write = 1'b1;
    step(1);
    ctl_write = 1'b0;
    step(1);
    check(speculative_request_enable, 1'b1);
    step(4);
  endtask : s_spec_off

  // early back-out on bare pci activity, then own-register access behind a posted write
  task automatic s_release_own();
    release_on_pci_activity = 1'b1;
    pci_active = 1'b1;
    step(4);
    cpu_issue(KIND_READ, 32'h00000400);
    wait_on(1, 1'b1, 6);
    check(bridge_lock, 1'b0);
    release_on_pci_activity = 1'b0;
    pci_active = 1'b0;
    pci_bound_empty = 1'b0;
    step(4);
    cpu_issue(KIND_POSTED, 32'h00000055);
    wait_on(0, 1'b1, 4);
    cpu_issue(KIND_OWN_REG, 32'h00000066);
    step(4);
    check({cpu_ack, cpu_wait}, 2'h1);
    pci_bound_empty = 1'b1;
    wait_on(0, 1'b1, 8);
    check(far.log_q.pop_front(), 32'h00000055);
    step(4);
  endtask : s_release_own

  task automatic s_pci_flush();
    pci_flush_before_read = 1'b1;
    pci_read_decoded = 1'b1;
    cpu_bound_empty = 1'b0;
    wait_on(4, 1'b1, 6);
    cpu_bound_empty = 1'b1;
    wait_on(4, 1'b0, 6);
    pci_flush_before_read = 1'b0;
    cpu_bound_empty = 1'b0;
    step(5);
    check(pci_read_wait, 1'b0);
    cpu_bound_empty = 1'b1;
    pci_read_decoded = 1'b0;
    step(4);
  endtask : s_pci_flush

  // last: the read retried under cpu flush-before-read is never queued, so the model answers only the second read
  task automatic s_cpu_flush();
    cpu_flush_before_read = 1'b1;
    pci_posted_pending = 1'b1;
    hold = 1'b1;
    step(3);
    cpu_issue(KIND_READ, 32'h00000200);
    wait_on(1, 1'b1, 10);
    pci_posted_pending = 1'b0;
    step(3);
    pci_bound_empty = 1'b0;
    hold = 1'b0;
    cpu_issue(KIND_READ, 32'h00000300);
    wait_on(7, 1'b1, 6);
    step(5);
    check(cpu_ack, 1'b0);
    pci_bound_empty = 1'b1;
    wait_on(0, 1'b1, 20);
  endtask : s_cpu_flush

  initial begin
    step(3);
    srst = 1'b0;
    check({cmd_valid, cpu_ack, cpu_retry, cpu_stall, pci_req, bridge_lock}, 6'h0);
    check(speculative_request_enable, SPEC_EN_RESET);
    s_posted_pending();
    s_order_buffer();
    s_lock_read(2'h0);
    s_lock_read(2'h1);
    s_lock_read(2'h2);
    s_spec_off();
    s_release_own();
    s_pci_flush();
    s_cpu_flush();
    conclude();
  end
endmodule : testbench
